/* File: rtl/cvc_pkg.sv */
// Constants, field layout and carrier types for the comparator and reference control block.
// Assumes an APB master with 32-bit data; all registers are 16 bits in the low half of a word.
`default_nettype none

package cvc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam int           CVC_NUM_CMP      = 3;
	localparam logic [7:0]   CVC_OFS_CTL_BASE = 8'h00;
	localparam logic [7:0]   CVC_OFS_CTL_STEP = 8'h04;
	localparam logic [7:0]   CVC_OFS_STAT     = 8'h0C;
	localparam logic [7:0]   CVC_OFS_VREF     = 8'h10;
	localparam logic [7:0]   CVC_OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0]   CVC_OFS_IRQ_MASK = 8'h18;

	// ==========================================================
	// Field positions
	localparam int           CVC_CTL_EVT      = 9;
	localparam int           CVC_CTL_OUT      = 8;
	localparam int           CVC_CTL_REF      = 4;
	localparam int           CVC_CTL_CH_LO    = 0;
	localparam int           CVC_STAT_IDLE    = 15;
	localparam int           CVC_STAT_EVT_LO  = 8;
	localparam int           CVC_STAT_OUT_LO  = 0;
	localparam int           CVC_VREF_EN      = 7;
	localparam int           CVC_VREF_OE      = 6;
	localparam int           CVC_VREF_RR      = 5;
	localparam int           CVC_VREF_SS      = 4;
	localparam int           CVC_VREF_LVL_LO  = 0;

	// ==========================================================
	// Reset values
	localparam logic [15:0]  CVC_RST_WORD     = 16'h0000;
	localparam logic [2:0]   CVC_RST_BITS     = 3'h0;
	localparam logic [15:0]  CVC_HI_ZERO      = 16'h0000;

	// ==========================================================
	// Carrier types
	typedef enum logic [1:0] {
		CVC_CH_PIN_B   = 2'b00,
		CVC_CH_PIN_C   = 2'b01,
		CVC_CH_PIN_D   = 2'b10,
		CVC_CH_HALF_BG = 2'b11
	} cvc_chan_type;

	typedef struct packed {
		logic         noninv_input_select;
		cvc_chan_type inv_input_channel;
	} cvc_cmp_ctrl_type;

	typedef struct packed {
		logic         ref_power_on;
		logic         ref_pin_drive;
		logic         ref_range_select;
		logic         ref_source_select;
		logic [3:0]   ref_level;
	} cvc_ref_ctrl_type;

endpackage : cvc_pkg

`default_nettype wire

/* File: rtl/cvc_comparator_vref_control.sv */
// Register bank and event logic for three analog comparators and the voltage reference.
// Assumes comparator results and the idle indication arrive synchronous to pclk.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none

// Overview of operation
// - Reference select bit routes non-inverting input to reference, else pin A.
// - Channel field picks inverting input: 11 half bandgap, 10 D, 01 C, 00 B.
// - Unimplemented bits read zero and ignore writes.
// - Idle suppress bit blocks interrupts in idle; comparing continues.
// - Status bits 10..8 mirror event flags of comparators 3..1.
// - Status bits 2..0 mirror result bits of comparators 3..1.
// - Reference enable powers the reference circuit; resets to zero.
// - Pin drive bit connects the reference level to its output pin.
// - Range bit picks 0..0.625 in 1/24 steps or 0.25..0.719 in 1/32.
// - Source bit picks external reference pins or analog supply rails.
// - Four-bit level field selects one of sixteen reference levels.
// - Set event flag blocks further triggers and interrupts until cleared.
module cvc_comparator_vref_control #(
	parameter int NUM_CMP = 3
) (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output var  logic [31:0]                          prdata,
	output var  logic                                 pready,
	output var  logic                                 pslverr,
	input  wire logic [2:0]                           cmp_result,
	input  wire logic                                 idle_mode,
	output var  cvc_pkg::cvc_cmp_ctrl_type [2:0]      cmp_ctrl,
	output var  cvc_pkg::cvc_ref_ctrl_type            ref_ctrl,
	output var  logic [2:0]                           cmp_trigger,
	output var  logic                                 irq
);
	import cvc_pkg::*;

	// ==========================================================
	// Elaboration check
	// Status layout holds exactly three comparators
	if (NUM_CMP != CVC_NUM_CMP) begin : g_bad_num
		$error("NUM_CMP must be 3");
	end

	// ==========================================================
	// State
	logic [2:0]  evt_flag;
	logic [2:0]  res;
	logic        idle_sup;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic [2:0]  trig;
	logic [2:0]  wr_ctl;
	logic        wr;
	logic        wr_stat;
	logic        wr_vref;
	logic        wr_istat;
	logic        wr_imask;
	logic        setup;
	logic        hit;
	logic [15:0] rd_word;

	// ==========================================================
	// APB decode
	assign setup    = psel & ~penable;
	assign wr       = psel & penable & pready & pwrite;
	assign wr_stat  = wr & (paddr == CVC_OFS_STAT);
	assign wr_vref  = wr & (paddr == CVC_OFS_VREF);
	assign wr_istat = wr & (paddr == CVC_OFS_IRQ_STAT);
	assign wr_imask = wr & (paddr == CVC_OFS_IRQ_MASK);

	function automatic logic [15:0] ctl_word(input int i);
		ctl_word = CVC_RST_WORD;
		ctl_word[CVC_CTL_EVT] = evt_flag[i];
		ctl_word[CVC_CTL_OUT] = res[i];
		ctl_word[CVC_CTL_REF] = cmp_ctrl[i].noninv_input_select;
		ctl_word[CVC_CTL_CH_LO +: 2] = cmp_ctrl[i].inv_input_channel;
	endfunction : ctl_word

	always_comb begin
		rd_word = CVC_RST_WORD;
		hit     = 1'b1;
		case (paddr)
			CVC_OFS_CTL_BASE:                           rd_word = ctl_word(0);
			CVC_OFS_CTL_BASE + CVC_OFS_CTL_STEP:        rd_word = ctl_word(1);
			CVC_OFS_CTL_BASE + 8'(2 * CVC_OFS_CTL_STEP): rd_word = ctl_word(2);
			CVC_OFS_STAT: begin
				rd_word[CVC_STAT_IDLE] = idle_sup;
				rd_word[CVC_STAT_EVT_LO +: 3] = evt_flag;
				rd_word[CVC_STAT_OUT_LO +: 3] = res;
			end
			CVC_OFS_VREF:     rd_word = {8'h00, ref_ctrl};
			CVC_OFS_IRQ_STAT: rd_word = {13'h0000, irq_stat};
			CVC_OFS_IRQ_MASK: rd_word = {13'h0000, irq_mask};
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// No wait state: data captured in setup, answered in first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			prdata  <= setup ? {CVC_HI_ZERO, rd_word} : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Per comparator control and event
	for (genvar i = 0; i < 3; i++) begin : g_cmp
		assign wr_ctl[i] = wr & (paddr == CVC_OFS_CTL_BASE + 8'(i * CVC_OFS_CTL_STEP));
		// Only a clear flag lets a transition through
		assign trig[i] = (cmp_result[i] ^ res[i]) & ~evt_flag[i];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cmp_ctrl[i] <= '{1'b0, CVC_CH_PIN_B};
			end else if (wr_ctl[i]) begin
				cmp_ctrl[i].noninv_input_select <= pwdata[CVC_CTL_REF];
				cmp_ctrl[i].inv_input_channel <= cvc_chan_type'(pwdata[CVC_CTL_CH_LO +: 2]);
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				evt_flag[i]    <= 1'b0;
				res[i]         <= 1'b0;
				cmp_trigger[i] <= 1'b0;
			end else begin
				res[i]         <= cmp_result[i];
				cmp_trigger[i] <= trig[i];
				if (trig[i]) begin
					evt_flag[i] <= 1'b1;
				end else if (wr_ctl[i]) begin
					evt_flag[i] <= pwdata[CVC_CTL_EVT];
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				irq_stat[i] <= 1'b0;
			end else begin
				// No interrupt while idle and suppressed
				if (trig[i] & ~(idle_mode & idle_sup)) begin
					irq_stat[i] <= 1'b1;
				end else if (wr_istat & pwdata[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Status, mask and interrupt line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_sup <= 1'b0;
			irq_mask <= CVC_RST_BITS;
			irq      <= 1'b0;
		end else begin
			if (wr_stat) begin
				idle_sup <= pwdata[CVC_STAT_IDLE];
			end
			if (wr_imask) begin
				irq_mask <= pwdata[2:0];
			end
			// Registered, so the line trails the status bit by one cycle
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==========================================================
	// Reference control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_ctrl <= '0;
		end else if (wr_vref) begin
			ref_ctrl.ref_power_on      <= pwdata[CVC_VREF_EN];
			ref_ctrl.ref_pin_drive     <= pwdata[CVC_VREF_OE];
			ref_ctrl.ref_range_select  <= pwdata[CVC_VREF_RR];
			ref_ctrl.ref_source_select <= pwdata[CVC_VREF_SS];
			ref_ctrl.ref_level         <= pwdata[CVC_VREF_LVL_LO +: 4];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence stat_read_s;
		psel && !penable && paddr == CVC_OFS_STAT;
	endsequence

	sequence ctl_read_s;
		psel && !penable && paddr == CVC_OFS_CTL_BASE;
	endsequence

	sequence vref_read_s;
		psel && !penable && paddr == CVC_OFS_VREF;
	endsequence

	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence apb_access_s;
		psel && penable;
	endsequence

	ref_route_w_a: assert property (
		wr_ctl[0] |=> cmp_ctrl[0].noninv_input_select == $past(pwdata[4]))
		else $error("non-inverting route not updated");
	chan_sel_w_a: assert property (
		wr_ctl[1] |=> cmp_ctrl[1].inv_input_channel == $past(pwdata[1:0]))
		else $error("inverting channel not updated");
	rsvd_zero_a: assert property (
		pready |-> prdata[31:16] == 16'h0000)
		else $error("reserved read bits not zero");
	idle_block_a: assert property (
		idle_mode && idle_sup && trig[0] && !irq_stat[0] |=> !irq_stat[0])
		else $error("interrupt set during suppressed idle");
	evt_mirror_a: assert property (
		stat_read_s |=> prdata[10:8] == $past(evt_flag))
		else $error("event mirror mismatch");
	res_mirror_a: assert property (
		stat_read_s |=> prdata[2:0] == $past(res) && prdata[7:3] == 5'h00)
		else $error("result mirror mismatch");
	ref_power_a: assert property (
		wr_vref |=> ref_ctrl.ref_power_on == $past(pwdata[7]))
		else $error("reference power not updated");
	ref_pin_a: assert property (
		wr_vref |=> ref_ctrl.ref_pin_drive == $past(pwdata[6]))
		else $error("reference pin drive not updated");
	ref_range_a: assert property (
		wr_vref |=> ref_ctrl.ref_range_select == $past(pwdata[5]))
		else $error("range select not updated");
	ref_source_a: assert property (
		wr_vref |=> ref_ctrl.ref_source_select == $past(pwdata[4]))
		else $error("source select not updated");
	ref_level_a: assert property (
		!wr_vref |=> ref_ctrl.ref_level == $past(ref_ctrl.ref_level))
		else $error("level changed without write");
	evt_block_a: assert property (
		evt_flag[2] |=> !cmp_trigger[2] ##0 !$rose(irq_stat[2]))
		else $error("trigger while event flag set");
	evt_set_wins_a: assert property (
		trig[0] && wr_ctl[0] && !pwdata[9] |=> evt_flag[0] && cmp_trigger[0])
		else $error("event lost to clear");

	// ==========================================================
	// Bus answer and readback
	apb_answer_a: assert property (
		apb_setup_s ##1 apb_access_s |-> pready)
		else $error("no answer in first access cycle");
	idle_data_a: assert property (
		!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("read data outside answer cycle");
	unmapped_a: assert property (
		setup && paddr > CVC_OFS_IRQ_MASK |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped address not refused");
	ctl_rsvd_a: assert property (
		ctl_read_s |=> prdata[15:10] == 6'h00 && prdata[7:5] == 3'h0 && prdata[3:2] == 2'h0)
		else $error("control reserved bits not zero");
	stat_rsvd_a: assert property (
		stat_read_s |=> prdata[14:11] == 4'h0)
		else $error("status reserved bits not zero");
	vref_read_a: assert property (
		vref_read_s |=> prdata[15:8] == 8'h00 && prdata[7:0] == $past(ref_ctrl))
		else $error("reference readback mismatch");
	stat_ro_a: assert property (
		wr_stat && trig == 3'h0 |=> evt_flag == $past(evt_flag))
		else $error("event mirror written");
	res_track_a: assert property (
		1'b1 |=> res == $past(cmp_result))
		else $error("result mirror lags");

	// ==========================================================
	// Configuration holding and update, interrupt outside suppressed idle
	cfg_hold_a: assert property (
		!wr_ctl[2] |=> $stable(cmp_ctrl[2]))
		else $error("routing changed without write");
	chan_hold_a: assert property (
		!wr_ctl[0] |=> $stable(cmp_ctrl[0].inv_input_channel))
		else $error("channel changed without write");
	vref_hold_a: assert property (
		!wr_vref |=> $stable(ref_ctrl))
		else $error("reference control changed without write");
	ref_level_w_a: assert property (
		wr_vref |=> ref_ctrl.ref_level == $past(pwdata[3:0]))
		else $error("level not updated");
	idle_sup_w_a: assert property (
		wr_stat |=> idle_sup == $past(pwdata[15]))
		else $error("idle suppress not updated");
	idle_pass_a: assert property (
		trig[1] && !(idle_mode && idle_sup) |=> irq_stat[1])
		else $error("interrupt lost outside suppressed idle");

	// ==========================================================
	// Events and interrupt line
	evt_sets_a: assert property (
		trig[1] |=> evt_flag[1] && cmp_trigger[1])
		else $error("event not recorded");
	evt_hold_a: assert property (
		evt_flag[1] && !wr_ctl[1] |=> evt_flag[1])
		else $error("event flag dropped without write");
	evt_clear_a: assert property (
		wr_ctl[1] && !trig[1] |=> evt_flag[1] == $past(pwdata[9]))
		else $error("event flag write lost");
	trig_pulse_a: assert property (
		cmp_trigger[0] |=> !cmp_trigger[0])
		else $error("trigger longer than one cycle");
	irq_clear_a: assert property (
		wr_istat && pwdata[0] && !trig[0] |=> !irq_stat[0])
		else $error("interrupt status not cleared");
	mask_w_a: assert property (
		wr_imask |=> irq_mask == $past(pwdata[2:0]))
		else $error("mask not updated");
	irq_follow_a: assert property (
		|(irq_stat & irq_mask) |=> irq)
		else $error("interrupt line missing");
	irq_quiet_a: assert property (
		!(|(irq_stat & irq_mask)) |=> !irq)
		else $error("interrupt line without cause");

endmodule : cvc_comparator_vref_control

`default_nettype wire

/* File: testbench/cvc_analog_model.sv */
// Behavioural analog side: three comparators and the reference ladder.
// Assumes pin levels in 1/96 steps of the supply span, set by the bench.
`default_nettype none

module cvc_analog_model #(
	parameter int HALF_BG  = 30,
	parameter int EXT_SPAN = 48
) (
	input  wire logic                            pclk,
	input  wire cvc_pkg::cvc_cmp_ctrl_type [2:0] cmp_ctrl,
	input  wire cvc_pkg::cvc_ref_ctrl_type       ref_ctrl,
	input  wire logic [7:0]                      pin_a,
	input  wire logic [7:0]                      pin_b,
	input  wire logic [7:0]                      pin_c,
	input  wire logic [7:0]                      pin_d,
	output var  logic [2:0]                      cmp_result
);
	import cvc_pkg::*;
	int vref;
	// ==========================================================
	// Reference ladder
	// ladder level
	always_comb begin
		vref = ref_ctrl.ref_range_select ? 4 * ref_ctrl.ref_level : 24 + 3 * ref_ctrl.ref_level;
		vref = ref_ctrl.ref_source_select ? vref * EXT_SPAN / 96 : vref;
		vref = ref_ctrl.ref_power_on ? vref : 0;
	end
	function automatic int inv_level(input cvc_chan_type ch);
		case (ch)
			CVC_CH_PIN_B: return int'(pin_b);
			CVC_CH_PIN_C: return int'(pin_c);
			CVC_CH_PIN_D: return int'(pin_d);
			default: return HALF_BG;
		endcase
	endfunction : inv_level
	// ==========================================================
	// Comparators, one clock of settling
	// non-inverting input routing
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 3; i++) begin
			cmp_result[i] <= (cmp_ctrl[i].noninv_input_select ? vref : int'(pin_a))
				> inv_level(cmp_ctrl[i].inv_input_channel);
		end
	end
endmodule : cvc_analog_model

`default_nettype wire

/* File: testbench/cvc_comparator_vref_control_test.sv */
// Self-checking bench for the comparator and reference control block.
// Assumes the analog model answers one clock after its controls change.
`default_nettype none

module cvc_comparator_vref_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cvc_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] x; logic e;} cvc_row_type;
	logic             pclk, presetn, psel, penable, pwrite, idle_mode, pready, pslverr, irq, perr;
	logic [7:0]       paddr, pin_a, pin_b, pin_c, pin_d;
	logic [31:0]      pwdata, prdata, rdata;
	logic [2:0]       cmp_result, cmp_trigger;
	cvc_cmp_ctrl_type [2:0] cmp_ctrl;
	cvc_ref_ctrl_type ref_ctrl;
	int               err_count = 0, checked = 0, trig_cnt = 0, t0;
	logic [15:0]      ctl_v [8] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013,
		16'h0000, 16'h0010, 16'h0010, 16'h0010};
	logic [7:0]       ref_v [8] = '{8'hEA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hBA, 8'h8A, 8'h6A};
	logic [7:0]       res_v = 8'h49;
	logic [7:0]       evt_v = 8'hFB;
	cvc_row_type      rows [19] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0},
		'{0, 8'h10, 0, 0, 0}, '{0, 8'h18, 0, 0, 0}, '{1, 8'h10, 16'hFFFF, 0, 0},
		'{0, 8'h10, 0, 16'h00FF, 0}, '{1, 8'h10, 0, 0, 0}, '{1, 8'h00, 16'hFDFF, 0, 0},
		'{0, 8'h00, 0, 16'h0013, 0}, '{1, 8'h04, 16'h0002, 0, 0}, '{1, 8'h08, 16'h0003, 0, 0},
		'{0, 8'h08, 0, 16'h0003, 0}, '{1, 8'h0C, 16'hFFFF, 0, 0}, '{0, 8'h0C, 0, 16'h8000, 0},
		'{1, 8'h0C, 0, 0, 0}, '{1, 8'h18, 16'hFFFF, 0, 0}, '{0, 8'h18, 0, 16'h0007, 0},
		'{0, 8'h1C, 0, 0, 1}, '{1, 8'h1C, 16'hFFFF, 0, 1}};
	cvc_comparator_vref_control i_cvc_comparator_vref_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_result(cmp_result), .idle_mode(idle_mode), .cmp_ctrl(cmp_ctrl),
		.ref_ctrl(ref_ctrl), .cmp_trigger(cmp_trigger), .irq(irq));
	cvc_analog_model i_cvc_analog_model (
		.pclk(pclk), .cmp_ctrl(cmp_ctrl), .ref_ctrl(ref_ctrl), .pin_a(pin_a), .pin_b(pin_b),
		.pin_c(pin_c), .pin_d(pin_d), .cmp_result(cmp_result));
	// ==========================================================
	// Clock, trigger count, watchdog
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (cmp_trigger[0] === 1'b1) begin
			trig_cnt <= trig_cnt + 1;
		end
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) err_count++;
		rdata = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		apb(1'b0, a, 16'h0000);
		chk("read data", rdata, {16'h0000, x});
	endtask : rd
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	// ==========================================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, idle_mode} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{pin_a, pin_b, pin_c, pin_d} = 32'h0A14_3250;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("row read", rdata, {16'h0000, rows[i].x});
			chk("row error", perr, rows[i].e);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, CVC_OFS_CTL_BASE, ctl_v[i]);
			apb(1'b1, CVC_OFS_VREF, {8'h00, ref_v[i]});
			repeat (4) @(posedge pclk);
			chk("routing", cmp_ctrl[0], {ctl_v[i][4], ctl_v[i][1:0]});
			chk("ref", ref_ctrl, ref_v[i]);
			rd(CVC_OFS_STAT, {7'h00, evt_v[i], 7'h00, res_v[i]});
			rd(CVC_OFS_CTL_BASE, {6'h00, evt_v[i], res_v[i], 3'h0, ctl_v[i][4:0]});
		end
		apb(1'b1, CVC_OFS_CTL_BASE, 16'h0010);
		apb(1'b1, CVC_OFS_IRQ_STAT, 16'h0007);
		t0 = trig_cnt;
		apb(1'b1, CVC_OFS_VREF, 16'h00AA);
		repeat (4) @(posedge pclk);
		chk("trigger", trig_cnt, t0 + 1);
		chk("irq on", irq, 1'b1);
		apb(1'b1, CVC_OFS_VREF, 16'h002A);
		apb(1'b1, CVC_OFS_IRQ_STAT, 16'h0007);
		repeat (4) @(posedge pclk);
		chk("blocked", trig_cnt, t0 + 1);
		chk("irq off", irq, 1'b0);
		apb(1'b1, CVC_OFS_IRQ_MASK, 16'h0000);
		apb(1'b1, CVC_OFS_CTL_BASE, 16'h0010);
		apb(1'b1, CVC_OFS_VREF, 16'h00AA);
		repeat (4) @(posedge pclk);
		chk("masked", irq, 1'b0);
		rd(CVC_OFS_IRQ_STAT, 16'h0001);
		apb(1'b1, CVC_OFS_IRQ_MASK, 16'h0007);
		repeat (2) @(posedge pclk);
		chk("unmasked", irq, 1'b1);
		apb(1'b1, CVC_OFS_IRQ_STAT, 16'h0007);
		apb(1'b1, CVC_OFS_STAT, 16'h8000);
		idle_mode <= 1'b1;
		apb(1'b1, CVC_OFS_CTL_BASE, 16'h0010);
		apb(1'b1, CVC_OFS_VREF, 16'h002A);
		repeat (4) @(posedge pclk);
		chk("idle irq", irq, 1'b0);
		rd(CVC_OFS_STAT, 16'h8100);
		idle_mode <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset ref", ref_ctrl, 8'h00);
		chk("reset irq", irq, 1'b0);
		chk("reset routing", cmp_ctrl, 9'h000);
		rd(CVC_OFS_STAT, 16'h0000);
		end_of_test();
	end
endmodule : cvc_comparator_vref_control_test

`default_nettype wire
